// File: rtl/sclkg_pkg.sv
// sclkg_pkg: offsets, field positions, reset values and counts for the
// system clock generator.
// assumes pclk stands for the pll clock in behaviour; apb byte addressing.
package sclkg_pkg;

    // bus clock
    localparam int PCLK_HZ = 20_000_000;
    localparam int PCLK_PERIOD_NS = 50;

    // source and pll figures
    localparam int INT_OSC_HZ = 24_000_000;
    localparam int PLL_MULT = 4;
    localparam int PLL_HZ = INT_OSC_HZ * PLL_MULT;
    localparam int USB_DIV = 2;
    localparam int USB_HZ = PLL_HZ / USB_DIV;
    localparam int FLASH_FAST_LIMIT_HZ = 16_000_000;

    // register indices; byte address is four times the index
    localparam logic [9:0] CFG_INDEX = 10'h0b9;
    localparam logic [9:0] KEY_INDEX = 10'h0a1;
    localparam logic [9:0] STAT_INDEX = 10'h0ba;

    // configuration register fields
    localparam int CFG_INT_OSC_BIT = 7;
    localparam int CFG_XT_OSC_BIT = 6;
    localparam int CFG_WDOG_BIT = 5;
    localparam int CFG_FLASH_BIT = 4;
    localparam int CFG_RST_BIT = 3;
    localparam int CFG_DIV_LSB = 0;
    localparam logic [7:0] CFG_RESET = 8'h83;
    localparam logic [2:0] DIV_RESET = 3'h3;

    // status register fields
    localparam int STAT_SRC_BIT = 0;
    localparam int STAT_SAFE_BIT = 1;

    // key register bytes
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // safe mode natural expiry, longest time rounds down
    localparam int SAFE_TIME_NS = 3200;
    localparam int SAFE_CYCLES = SAFE_TIME_NS / PCLK_PERIOD_NS;

    // divider codes
    localparam logic [2:0] DIV_CODE_512 = 3'h0;
    localparam logic [2:0] DIV_CODE_128 = 3'h1;
    localparam logic [2:0] DIV_CODE_32 = 3'h2;
    localparam logic [2:0] DIV_CODE_16 = 3'h3;
    localparam logic [2:0] DIV_CODE_8 = 3'h4;
    localparam logic [2:0] DIV_CODE_6 = 3'h5;
    localparam logic [2:0] DIV_CODE_4 = 3'h6;
    localparam logic [2:0] DIV_CODE_OFF = 3'h7;
    localparam logic [8:0] DIV_HALF_RESET = 9'h008;

    typedef enum logic [1:0] {
        SAFE_IDLE,
        SAFE_GOT_FIRST,
        SAFE_OPEN
    } sclkg_safe_type;

    // half period in pll cycles; zero means clock stopped
    function automatic logic [8:0] sclkg_half_of(input logic [2:0] code);
        logic [8:0] h;
        h = 9'h000;
        case (code)
            DIV_CODE_512: h = 9'h100;
            DIV_CODE_128: h = 9'h040;
            DIV_CODE_32: h = 9'h010;
            DIV_CODE_16: h = 9'h008;
            DIV_CODE_8: h = 9'h004;
            DIV_CODE_6: h = 9'h003;
            DIV_CODE_4: h = 9'h002;
            default: h = 9'h000;
        endcase
        return h;
    endfunction

endpackage

// File: rtl/sclkg_div_if.sv
// sclkg_div_if: settings to the divider and its clock outputs back.
// assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface sclkg_div_if;
    logic [2:0] div_code;
    logic src_internal;
    logic sys_clk;
    logic sys_tick;
    logic src_active;
    modport ctrl(
        output div_code,
        output src_internal,
        input sys_clk,
        input sys_tick,
        input src_active
    );
    modport gen(
        input div_code,
        input src_internal,
        output sys_clk,
        output sys_tick,
        output src_active
    );
endinterface

// File: rtl/sclkg_divider.sv
// sclkg_divider: divides the pll clock into the system clock.
// assumes pclk stands for the pll clock; settings come over sclkg_div_if.
`timescale 1ns/1ps
module sclkg_divider
    import sclkg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    sclkg_div_if.gen div
);

    logic [8:0] half_r;
    logic [8:0] cnt_r;
    logic phase_r;
    logic tick_r;
    logic src_r;

    wire [8:0] new_half = sclkg_half_of(div.div_code);
    wire half_last = (cnt_r == (half_r - 9'h001));
    wire stopped = (half_r == 9'h000);
    wire boundary = stopped | (phase_r & half_last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_r <= DIV_HALF_RESET;
            cnt_r <= 9'h000;
            phase_r <= 1'b0;
            tick_r <= 1'b0;
            src_r <= 1'b1;
        end else if (boundary) begin
            half_r <= new_half;
            cnt_r <= 9'h000;
            phase_r <= 1'b0;
            tick_r <= (new_half != 9'h000);
            src_r <= div.src_internal;
        end else if (half_last) begin
            cnt_r <= 9'h000;
            phase_r <= ~phase_r;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 9'h001;
            tick_r <= 1'b0;
        end
    end

    assign div.sys_clk = phase_r;
    assign div.sys_tick = tick_r;
    assign div.src_active = src_r;

endmodule // sclkg_divider

// File: rtl/sclkg_top.sv
// sclkg_top: clock source select, pll model, system and usb dividers,
// safe-mode protected configuration register on apb.
// assumes pclk stands for the pll clock and all inputs are synchronous.
`timescale 1ns/1ps

// How it works
// - bit 7 runs and selects internal oscillator
// - bit 6 gives pins to crystal oscillator
// - watchdog flag sets; reload or isr clears
// - bit 4 picks flash reference clock rate
// - bit 3 reads reset pin level
// - three-bit code selects divide 512 to 4, code 7 stops the clock
// - reset value 83h, 6 MHz system clock
// - power-up source is 24 MHz internal
// - pll is four times source, feeds dividers
// - usb clock is pll divided by two
// - system clock goes to every module
// - config writes only while safe mode open
// - 55h then AAh opens safe mode
// - other key writes close safe mode early
module sclkg_top
    import sclkg_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int SAFE_LIMIT = SAFE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_level,
    input wire logic watchdog_overflow,
    input wire logic watchdog_count_reload,
    input wire logic watchdog_isr_enter,
    output logic internal_osc_enable,
    output logic crystal_osc_enable,
    output logic crystal_pin_mode,
    output logic source_internal,
    output logic flash_clock_speedup,
    output logic watchdog_overflow_flag,
    output logic safe_mode_active,
    output logic sys_clock_out,
    output logic sys_clock_tick,
    output logic usb_module_clock
);

    sclkg_div_if div_bus();

    logic osc_int_r;
    logic osc_xt_r;
    logic flash_fast_r;
    logic [2:0] div_sel_r;
    logic wdog_flag_r;
    logic rst_level_r;
    logic xt_pins_r;
    logic src_r;
    logic sys_clk_r;
    logic sys_tick_r;
    logic usb_clk_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    sclkg_safe_type safe_r;
    sclkg_safe_type safe_nxt;
    logic [15:0] safe_cnt_r;
    logic [15:0] safe_cnt_nxt;

    // bus decode
    wire [9:0] word_index = paddr[11:2];
    wire cfg_hit = (word_index == CFG_INDEX);
    wire key_hit = (word_index == KEY_INDEX);
    wire stat_hit = (word_index == STAT_INDEX);
    wire any_hit = cfg_hit | key_hit | stat_hit;
    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready_r;
    wire wr_done = access_done & pwrite & ~pslverr_r;
    wire cfg_wr = wr_done & cfg_hit;
    wire key_wr = wr_done & key_hit;
    wire [7:0] wbyte = pwdata[7:0];
    wire safe_open = (safe_r == SAFE_OPEN);

    // reset pin level in bit 3
    wire [7:0] cfg_word = {
        osc_int_r,
        osc_xt_r,
        wdog_flag_r,
        flash_fast_r,
        rst_level_r,
        div_sel_r
    };
    wire [7:0] stat_word = {
        6'h00,
        safe_open,
        src_r
    };
    wire [7:0] key_word = {7'h00, safe_open};
    wire [7:0] rd_byte = cfg_hit ? cfg_word :
                         key_hit ? key_word :
                         stat_hit ? stat_word : 8'h00;

    // apb answer: zero wait, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup_phase;
            pslverr_r <= setup_phase & ~any_hit;
            if (setup_phase & ~pwrite) begin
                prdata_r <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_comb begin
        safe_nxt = safe_r;
        safe_cnt_nxt = safe_cnt_r;
        case (safe_r)
            SAFE_IDLE: begin
                if (key_wr && wbyte == KEY_FIRST) begin
                    safe_nxt = SAFE_GOT_FIRST;
                end
            end
            SAFE_GOT_FIRST: begin
                if (key_wr && wbyte == KEY_SECOND) begin
                    safe_nxt = SAFE_OPEN;
                    safe_cnt_nxt = 16'h0000;
                end else if (key_wr && wbyte != KEY_FIRST) begin
                    safe_nxt = SAFE_IDLE;
                end
            end
            SAFE_OPEN: begin
                if (key_wr) begin
                    safe_nxt = (wbyte == KEY_FIRST) ? SAFE_GOT_FIRST
                                                    : SAFE_IDLE;
                end else if (safe_cnt_r == 16'(SAFE_LIMIT - 1)) begin
                    safe_nxt = SAFE_IDLE;
                end else begin
                    safe_cnt_nxt = safe_cnt_r + 16'h0001;
                end
            end
            default: begin
                safe_nxt = SAFE_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            safe_r <= SAFE_IDLE;
            safe_cnt_r <= 16'h0000;
        end else begin
            safe_r <= safe_nxt;
            safe_cnt_r <= safe_cnt_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_int_r <= CFG_RESET[CFG_INT_OSC_BIT];
            osc_xt_r <= CFG_RESET[CFG_XT_OSC_BIT];
            flash_fast_r <= CFG_RESET[CFG_FLASH_BIT];
            div_sel_r <= DIV_RESET;
        end else if (cfg_wr && safe_open) begin
            osc_int_r <= wbyte[CFG_INT_OSC_BIT];
            osc_xt_r <= wbyte[CFG_XT_OSC_BIT];
            flash_fast_r <= wbyte[CFG_FLASH_BIT];
            div_sel_r <= wbyte[CFG_DIV_LSB +: 3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_flag_r <= 1'b0;
        end else if (watchdog_overflow) begin
            wdog_flag_r <= 1'b1;
        end else if (watchdog_count_reload | watchdog_isr_enter) begin
            wdog_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_level_r <= 1'b0;
        end else begin
            rst_level_r <= reset_pin_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xt_pins_r <= 1'b0;
        end else begin
            xt_pins_r <= osc_xt_r;
        end
    end

    assign div_bus.src_internal = osc_int_r;
    assign div_bus.div_code = div_sel_r;

    sclkg_divider u_divider (
        .pclk(pclk),
        .presetn(presetn),
        .div(div_bus.gen)
    );

    // usb clock is pll over two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_r <= 1'b0;
            sys_tick_r <= 1'b0;
            src_r <= 1'b1;
            usb_clk_r <= 1'b0;
        end else begin
            sys_clk_r <= div_bus.sys_clk;
            sys_tick_r <= div_bus.sys_tick;
            src_r <= div_bus.src_active;
            usb_clk_r <= ~usb_clk_r;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign internal_osc_enable = osc_int_r;
    assign crystal_osc_enable = osc_xt_r;
    assign crystal_pin_mode = xt_pins_r;
    assign source_internal = src_r;
    assign flash_clock_speedup = flash_fast_r;
    assign watchdog_overflow_flag = wdog_flag_r;
    assign safe_mode_active = safe_open;
    assign sys_clock_out = sys_clk_r;
    assign sys_clock_tick = sys_tick_r;
    assign usb_module_clock = usb_clk_r;

endmodule // sclkg_top

// File: verification/sclkg_top_props.sv
// sclkg_top_props: port checks on the clock generator top.
// assumes apb byte addressing and the single clock pclk.
`timescale 1ns/1ps
module sclkg_top_props
    import sclkg_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int SAFE_LIMIT = SAFE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic watchdog_overflow,
    input wire logic watchdog_count_reload,
    input wire logic watchdog_isr_enter,
    input wire logic internal_osc_enable,
    input wire logic crystal_osc_enable,
    input wire logic crystal_pin_mode,
    input wire logic flash_clock_speedup,
    input wire logic watchdog_overflow_flag,
    input wire logic safe_mode_active,
    input wire logic sys_clock_tick,
    input wire logic usb_module_clock
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wdone = psel && penable && pready && pwrite;
    wire key_w = wdone && paddr[11:2] == KEY_INDEX;
    wire key_aa = key_w && pwdata[7:0] == KEY_SECOND;
    wire cfg_w = wdone && paddr[11:2] == CFG_INDEX;
    logic [7:0] open_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) open_r <= 8'h00;
        else open_r <= safe_mode_active ? open_r + 8'h01 : 8'h00;
    end
    property p_usb;
        $past(presetn) |-> usb_module_clock != $past(usb_module_clock);
    endproperty
    a_usb: assert property (p_usb) else $error("usb clock stuck");
    property p_pin;
        $past(presetn) |-> crystal_pin_mode == $past(crystal_osc_enable);
    endproperty
    a_pin: assert property (p_pin) else $error("pin mode lag");
    property p_locked;
        cfg_w && !safe_mode_active |=> $stable(internal_osc_enable)
            && $stable(crystal_osc_enable) && $stable(flash_clock_speedup);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write");
    property p_close;
        key_w && safe_mode_active |=> !safe_mode_active;
    endproperty
    a_close: assert property (p_close) else $error("safe stays open");
    property p_open;
        $rose(safe_mode_active) |-> $past(key_aa);
    endproperty
    a_open: assert property (p_open) else $error("safe opened bad");
    property p_expire;
        open_r <= SAFE_LIMIT;
    endproperty
    a_expire: assert property (p_expire) else $error("safe too long");
    property p_wset;
        watchdog_overflow |=> watchdog_overflow_flag;
    endproperty
    a_wset: assert property (p_wset) else $error("flag not set");
    property p_wclr;
        (watchdog_count_reload || watchdog_isr_enter) && !watchdog_overflow
            |=> !watchdog_overflow_flag;
    endproperty
    a_wclr: assert property (p_wclr) else $error("flag not clear");
    property p_tick;
        sys_clock_tick |=> !sys_clock_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick too long");
    c_open: cover property ($rose(safe_mode_active));
    c_cfg: cover property (cfg_w && safe_mode_active);
    c_wdog: cover property (watchdog_overflow_flag && watchdog_count_reload);
endmodule // sclkg_top_props
bind sclkg_top sclkg_top_props #(.ADDR_W(ADDR_W), .SAFE_LIMIT(SAFE_LIMIT))
    sclkg_top_props_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .watchdog_overflow, .watchdog_count_reload,
    .watchdog_isr_enter, .internal_osc_enable, .crystal_osc_enable,
    .crystal_pin_mode, .flash_clock_speedup, .watchdog_overflow_flag,
    .safe_mode_active, .sys_clock_tick, .usb_module_clock);

// File: verification/sclkg_xtal_model.sv
// sclkg_xtal_model: crystal on the two shared pins.
// assumes the pin mode output hands the pins over.
`timescale 1ns/1ps
module sclkg_xtal_model (
    input wire logic crystal_pin_mode,
    output logic crystal_input_pin
);
    initial crystal_input_pin = 1'b0;
    always begin
        #21;
        crystal_input_pin = crystal_pin_mode & ~crystal_input_pin;
    end
endmodule // sclkg_xtal_model

// File: verification/sclkg_top_tb.sv
// sclkg_top_tb: random and corner tests of the clock generator.
// assumes the apb slave answers with its own pready.
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
module sclkg_top_tb;
    import sclkg_pkg::*;
    localparam int LIM = 8;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, se, u;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rq, r;
    logic [7:0] v;
    logic reset_pin_level = 1'b0, watchdog_overflow = 1'b0;
    logic watchdog_count_reload = 1'b0, watchdog_isr_enter = 1'b0;
    logic internal_osc_enable, crystal_osc_enable, crystal_pin_mode;
    logic source_internal, flash_clock_speedup, watchdog_overflow_flag;
    logic safe_mode_active, sys_clock_out, sys_clock_tick;
    logic usb_module_clock, crystal_input_pin;
    int fails = 0, tests_run = 0, p;
    int divs[8] = '{512, 128, 32, 16, 8, 6, 4, 1200};
    always #25 pclk = ~pclk;
    sclkg_top #(.SAFE_LIMIT(LIM)) sclkg_top_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .reset_pin_level, .watchdog_overflow, .watchdog_count_reload,
        .watchdog_isr_enter, .internal_osc_enable, .crystal_osc_enable,
        .crystal_pin_mode, .source_internal, .flash_clock_speedup,
        .watchdog_overflow_flag, .safe_mode_active, .sys_clock_out,
        .sys_clock_tick, .usb_module_clock);
    sclkg_xtal_model sclkg_xtal_model_i (.crystal_pin_mode,
        .crystal_input_pin);
    task automatic summarize();
        $display("checks %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [9:0] i,
        input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            fails++;
            summarize();
        end
        rq = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic unlock();
        apb(1'b1, KEY_INDEX, KEY_FIRST);
        apb(1'b1, KEY_INDEX, KEY_SECOND);
    endtask
    task automatic tick_gap();
        repeat (2) begin
            p = 0;
            do begin
                @(posedge pclk);
                p++;
            end while (sys_clock_tick !== 1'b1 && p < 1200);
        end
    endtask
    initial begin
        void'($urandom(32'h902e7ef3));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CFG_INDEX, 8'h00);
        `CHK("cfg reset", 32'h83, rq)
        `CHK("int osc", 1'b1, internal_osc_enable)
        `CHK("xt idle", 1'b0, crystal_input_pin)
        tick_gap();
        `CHK("reset gap", 16, p)
        `CHK("sys low", 1'b0, sys_clock_out)
        repeat (8) @(posedge pclk);
        `CHK("sys high", 1'b1, sys_clock_out)
        u = usb_module_clock;
        @(posedge pclk);
        `CHK("usb", ~u, usb_module_clock)
        reset_pin_level <= 1'b1;
        apb(1'b1, CFG_INDEX, 8'h00);
        apb(1'b0, CFG_INDEX, 8'h00);
        `CHK("locked", 32'h8b, rq)
        apb(1'b0, 10'h000, 8'h00);
        `CHK("unmapped", 33'h100000000, {se, rq})
        apb(1'b1, KEY_INDEX, KEY_FIRST);
        apb(1'b1, KEY_INDEX, 8'h12);
        apb(1'b1, KEY_INDEX, KEY_SECOND);
        `CHK("bad key", 1'b0, safe_mode_active)
        apb(1'b1, KEY_INDEX, KEY_FIRST);
        unlock();
        `CHK("open", 1'b1, safe_mode_active)
        apb(1'b1, KEY_INDEX, 8'h00);
        `CHK("closed", 1'b0, safe_mode_active)
        unlock();
        repeat (LIM + 2) @(posedge pclk);
        `CHK("expired", 1'b0, safe_mode_active)
        $display("test keys done");
        for (int c = 0; c < 8; c++) begin
            r = $urandom;
            v = {1'b1, r[1], 1'b0, r[0], 1'b0, 3'(c)};
            reset_pin_level <= r[2];
            unlock();
            apb(1'b1, CFG_INDEX, v | 8'h28);
            apb(1'b0, CFG_INDEX, 8'h00);
            `CHK("cfg", {24'h0, v | {4'h0, r[2], 3'h0}}, rq)
            `CHK("xt pins", r[1], crystal_pin_mode)
            `CHK("flash", r[0], flash_clock_speedup)
            tick_gap();
            tick_gap();
            `CHK("gap", divs[c], p)
        end
        $display("test divider done");
        for (int k = 0; k < 2; k++) begin
            watchdog_overflow <= 1'b1;
            @(posedge pclk);
            watchdog_overflow <= 1'b0;
            apb(1'b0, CFG_INDEX, 8'h00);
            `CHK("wdog bit", 1'b1, rq[5])
            if (k == 0) watchdog_count_reload <= 1'b1;
            else watchdog_isr_enter <= 1'b1;
            @(posedge pclk);
            watchdog_count_reload <= 1'b0;
            watchdog_isr_enter <= 1'b0;
            @(posedge pclk);
            `CHK("wdog clr", 1'b0, watchdog_overflow_flag)
        end
        $display("test watchdog done");
        // divide 16 keeps sysclk at usb minimum
        unlock();
        apb(1'b1, CFG_INDEX, 8'hc3);
        repeat (40) @(posedge pclk);
        unlock();
        apb(1'b1, CFG_INDEX, 8'h43);
        tick_gap();
        tick_gap();
        `CHK("xt source", 1'b0, source_internal)
        `CHK("int off", 1'b0, internal_osc_enable)
        `CHK("xt gap", 16, p)
        $display("test crystal done");
        summarize();
    end
endmodule // sclkg_top_tb
